/* File: logic/lsgate_pkg.sv */
// Shared constants for the low-speed start gate and root hub descriptor block
package lsgate_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [AXI_AW-1:0] ADDR_THRESHOLD = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_DESCRIPTOR = 8'h04;
    localparam logic [AXI_AW-1:0] ADDR_CONTROL = 8'h08;
    localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h0C;
    localparam logic [AXI_AW-1:0] ADDR_DEFER_COUNT = 8'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and widths
    localparam int COUNT_W = 14;
    localparam int THR_LSB = 0;
    localparam int PGD_LSB = 24;
    localparam int PGD_W = 8;
    localparam int NO_OCP_BIT = 12;
    localparam int CTRL_RUN_BIT = 0;
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_GATE_BIT = 16;
    localparam int STAT_RUN_BIT = 17;
    localparam int DEFER_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [COUNT_W-1:0] THRESHOLD_RST = 14'h0000;
    localparam logic [PGD_W-1:0] PGD_RST = 8'h00;
    localparam logic NO_OCP_RST = 1'b1;
    localparam logic RUN_RST = 1'b0;
    localparam logic [COUNT_W-1:0] FRAME_LENGTH_RST = 14'h2EDF;

    ////////////////////////////////////////////////////////////////////////////
    // Power-good delay unit, held for software only
    localparam int POWER_GOOD_UNIT_MS = 2;

endpackage

/* File: logic/axi_lite_slave.sv */
// AXI4-Lite slave front end turning bus traffic into register strobes
`timescale 1ns/1ns
module axi_lite_slave
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [lsgate_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [lsgate_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [lsgate_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [lsgate_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [lsgate_pkg::AXI_AW-1:0] wr_addr,
    output logic [lsgate_pkg::AXI_DW-1:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [lsgate_pkg::AXI_AW-1:0] rd_addr,
    input wire logic [lsgate_pkg::AXI_DW-1:0] rd_data,
    input wire logic rd_err
);
    import lsgate_pkg::*;

    typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESPOND = 2'b10} wr_phase_t;

    typedef struct packed {
        wr_phase_t phase;
        logic aw_held;
        logic w_held;
        logic [AXI_AW-1:0] addr;
        logic [AXI_DW-1:0] data;
        logic [3:0] strb;
        logic [1:0] bresp;
        logic rvalid;
        logic [AXI_DW-1:0] rdata;
        logic [1:0] rresp;
    } slave_state_t;

    slave_state_t s_r;
    slave_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Handshakes; address and data may arrive in either order
    assign s_axi_awready = (s_r.phase == WR_COLLECT) && !s_r.aw_held;
    assign s_axi_wready = (s_r.phase == WR_COLLECT) && !s_r.w_held;
    assign s_axi_bvalid = (s_r.phase == WR_RESPOND);
    assign s_axi_bresp = s_r.bresp;
    assign wr_en = (s_r.phase == WR_COLLECT) && s_r.aw_held && s_r.w_held;
    assign wr_addr = s_r.addr;
    assign wr_data = s_r.data;
    assign wr_strb = s_r.strb;
    // One read in flight; a new address waits until the data is taken
    assign s_axi_arready = !s_r.rvalid;
    assign rd_en = s_axi_arvalid && !s_r.rvalid;
    assign rd_addr = s_axi_araddr;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;

    always_comb
    begin
        s_nxt = s_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_nxt.aw_held = 1'b1;
            s_nxt.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_nxt.w_held = 1'b1;
            s_nxt.data = s_axi_wdata;
            s_nxt.strb = s_axi_wstrb;
        end
        case (s_r.phase)
            WR_COLLECT:
            begin
                if (wr_en)
                begin
                    s_nxt.phase = WR_RESPOND;
                    s_nxt.aw_held = 1'b0;
                    s_nxt.w_held = 1'b0;
                    s_nxt.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
                end
            end
            WR_RESPOND:
            begin
                if (s_axi_bready)
                begin
                    s_nxt.phase = WR_COLLECT;
                end
            end
            default:
            begin
                s_nxt.phase = WR_COLLECT;
            end
        endcase
        if (rd_en)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = rd_data;
            s_nxt.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_r.rvalid && s_axi_rready)
        begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '{WR_COLLECT, 1'b0, 1'b0, '0, '0, 4'h0, RESP_OKAY, 1'b0, '0, RESP_OKAY};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule // axi_lite_slave

/* File: logic/frame_countdown.sv */
// Frame remaining counter, reloaded from the frame length at each frame start
`timescale 1ns/1ns
module frame_countdown
#(
    parameter int WIDTH = lsgate_pkg::COUNT_W
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic bit_tick,
    input wire logic [WIDTH-1:0] frame_length,
    output logic [WIDTH-1:0] remaining,
    output logic frame_start
);
    import lsgate_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic start;
    } count_state_t;

    count_state_t s_r;
    count_state_t s_nxt;

    assign remaining = s_r.count;
    assign frame_start = s_r.start;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        if (!run)
        begin
            // Held primed so the first frame after run starts full length
            s_nxt.count = frame_length;
        end
        else if (bit_tick)
        begin
            if (s_r.count == '0)
            begin
                s_nxt.count = frame_length;
                s_nxt.start = 1'b1;
            end
            else
            begin
                s_nxt.count = s_r.count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r <= '{'0, 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule // frame_countdown

/* File: logic/usb_lowspeed_gate.sv */
// Low-speed packet start gate and first root hub descriptor register
//
// Function
// - A 14-bit low-speed threshold sits in bits 13..0, in full-speed bit times.
// - A low-speed transaction starts only while frame remaining exceeds the threshold.
// - An 8-bit power-good delay sits in bits 31..24, each count being 2 ms.
// - The power-good delay is stored for software and steers no hardware.
// - Software may write the power-good delay field.
// - Bit 12 of the descriptor resets to 1, meaning no overcurrent inputs.
// - Frame remaining is a 14-bit bit-time count reloaded from frame length each frame.
`timescale 1ns/1ns
module usb_lowspeed_gate
#(
    parameter logic [lsgate_pkg::COUNT_W-1:0] THRESHOLD_INIT = lsgate_pkg::THRESHOLD_RST,
    parameter logic [lsgate_pkg::PGD_W-1:0] POWER_GOOD_INIT = lsgate_pkg::PGD_RST
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [lsgate_pkg::AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [lsgate_pkg::AXI_DW-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [lsgate_pkg::AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [lsgate_pkg::AXI_DW-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic BIT_TICK,
    input wire logic [lsgate_pkg::COUNT_W-1:0] FRAME_LENGTH_VALUE,
    input wire logic LS_REQUEST,
    output logic LS_START,
    output logic LS_DEFER,
    output logic [lsgate_pkg::COUNT_W-1:0] FRAME_REMAINING_COUNT,
    output logic FRAME_START
);
    import lsgate_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [COUNT_W-1:0] threshold;
        logic [PGD_W-1:0] power_good;
        logic no_ocp;
        logic run;
        logic defer_seen;
        logic [DEFER_W-1:0] defer_cnt;
    } gate_state_t;

    gate_state_t s_r;
    gate_state_t s_nxt;

    logic wr_en;
    logic [AXI_AW-1:0] wr_addr;
    logic [AXI_DW-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [AXI_AW-1:0] rd_addr;
    logic [AXI_DW-1:0] rd_data;
    logic rd_err;
    logic [COUNT_W-1:0] frame_remaining_count;
    logic gate_open;
    logic defer_event;
    logic defer_clear;
    logic [AXI_DW-1:0] threshold_word;
    logic [AXI_DW-1:0] descriptor_word;
    logic [AXI_DW-1:0] control_word;
    logic [AXI_DW-1:0] status_word;
    logic [AXI_DW-1:0] defer_word;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Byte-lane merge, shared by the threshold, descriptor and control registers
    function automatic logic [AXI_DW-1:0] merge_bytes(
        input logic [AXI_DW-1:0] old_v,
        input logic [AXI_DW-1:0] new_v,
        input logic [3:0] strb
    );
        logic [AXI_DW-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Address decode, shared by the read and write paths
    function automatic logic reg_mapped(input logic [AXI_AW-1:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            ADDR_THRESHOLD: hit = 1'b1;
            ADDR_DESCRIPTOR: hit = 1'b1;
            ADDR_CONTROL: hit = 1'b1;
            ADDR_STATUS: hit = 1'b1;
            ADDR_DEFER_COUNT: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    axi_lite_slave u_slave
    (
        .clk(CLK),
        .rst(SYS_RST),
        .s_axi_awaddr(S_AXI_AWADDR),
        .s_axi_awvalid(S_AXI_AWVALID),
        .s_axi_awready(S_AXI_AWREADY),
        .s_axi_wdata(S_AXI_WDATA),
        .s_axi_wstrb(S_AXI_WSTRB),
        .s_axi_wvalid(S_AXI_WVALID),
        .s_axi_wready(S_AXI_WREADY),
        .s_axi_bresp(S_AXI_BRESP),
        .s_axi_bvalid(S_AXI_BVALID),
        .s_axi_bready(S_AXI_BREADY),
        .s_axi_araddr(S_AXI_ARADDR),
        .s_axi_arvalid(S_AXI_ARVALID),
        .s_axi_arready(S_AXI_ARREADY),
        .s_axi_rdata(S_AXI_RDATA),
        .s_axi_rresp(S_AXI_RRESP),
        .s_axi_rvalid(S_AXI_RVALID),
        .s_axi_rready(S_AXI_RREADY),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    assign wr_err = !reg_mapped(wr_addr);
    assign rd_err = !reg_mapped(rd_addr);

    ////////////////////////////////////////////////////////////////////////////
    // Frame remaining counter

    frame_countdown #(.WIDTH(COUNT_W)) u_countdown
    (
        .clk(CLK),
        .rst(SYS_RST),
        .run(s_r.run),
        .bit_tick(BIT_TICK),
        .frame_length(FRAME_LENGTH_VALUE),
        .remaining(frame_remaining_count),
        .frame_start(FRAME_START)
    );

    assign FRAME_REMAINING_COUNT = frame_remaining_count;

    ////////////////////////////////////////////////////////////////////////////
    // Low-speed start gate

    // Strictly greater: at equality there is no longer room for the packet
    assign gate_open = s_r.run && (frame_remaining_count > s_r.threshold);
    assign LS_START = LS_REQUEST && gate_open;
    assign LS_DEFER = LS_REQUEST && !gate_open;
    // Count each deferral once, not every cycle the request waits
    assign defer_event = LS_DEFER && !s_r.defer_seen;
    assign defer_clear = wr_en && (wr_addr == ADDR_DEFER_COUNT);

    ////////////////////////////////////////////////////////////////////////////
    // Register views; reserved bits are tied to zero here

    always_comb
    begin
        threshold_word = '0;
        threshold_word[THR_LSB +: COUNT_W] = s_r.threshold;
        descriptor_word = '0;
        descriptor_word[PGD_LSB +: PGD_W] = s_r.power_good;
        descriptor_word[NO_OCP_BIT] = s_r.no_ocp;
        control_word = '0;
        control_word[CTRL_RUN_BIT] = s_r.run;
        status_word = '0;
        status_word[STAT_COUNT_LSB +: COUNT_W] = frame_remaining_count;
        status_word[STAT_GATE_BIT] = gate_open;
        status_word[STAT_RUN_BIT] = s_r.run;
        defer_word = '0;
        defer_word[DEFER_W-1:0] = s_r.defer_cnt;
    end

    always_comb
    begin
        case (rd_addr)
            ADDR_THRESHOLD: rd_data = threshold_word;
            ADDR_DESCRIPTOR: rd_data = descriptor_word;
            ADDR_CONTROL: rd_data = control_word;
            ADDR_STATUS: rd_data = status_word;
            ADDR_DEFER_COUNT: rd_data = defer_word;
            default: rd_data = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register updates

    always_comb
    begin
        logic [AXI_DW-1:0] merged;
        logic [DEFER_W-1:0] defer_base;
        merged = '0;
        defer_base = '0;
        s_nxt = s_r;
        s_nxt.defer_seen = LS_DEFER;
        if (wr_en)
        begin
            case (wr_addr)
                ADDR_THRESHOLD:
                begin
                    merged = merge_bytes(threshold_word, wr_data, wr_strb);
                    s_nxt.threshold = merged[THR_LSB +: COUNT_W];
                end
                ADDR_DESCRIPTOR:
                begin
                    merged = merge_bytes(descriptor_word, wr_data, wr_strb);
                    // Stored only; nothing in the gate or counter reads it
                    s_nxt.power_good = merged[PGD_LSB +: PGD_W];
                    s_nxt.no_ocp = merged[NO_OCP_BIT];
                end
                ADDR_CONTROL:
                begin
                    merged = merge_bytes(control_word, wr_data, wr_strb);
                    s_nxt.run = merged[CTRL_RUN_BIT];
                end
                default:
                begin
                    merged = '0;
                end
            endcase
        end
        // A deferral in the clearing cycle survives as a count of one
        defer_base = defer_clear ? '0 : s_r.defer_cnt;
        if (defer_event && (defer_base != '1))
        begin
            defer_base = defer_base + 1'b1;
        end
        s_nxt.defer_cnt = defer_base;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            s_r.threshold <= THRESHOLD_INIT;
            s_r.power_good <= POWER_GOOD_INIT;
            s_r.no_ocp <= NO_OCP_RST;
            s_r.run <= RUN_RST;
            s_r.defer_seen <= 1'b0;
            s_r.defer_cnt <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule // usb_lowspeed_gate

/* File: verification/lsgate_checker_asserts.sv */
// Checker for the low-speed gate ports, bound to the top module
`timescale 1ns/1ns
module lsgate_checker
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic BIT_TICK,
    input wire logic [13:0] FRAME_LENGTH_VALUE,
    input wire logic LS_REQUEST,
    input wire logic LS_START,
    input wire logic LS_DEFER,
    input wire logic [13:0] FRAME_REMAINING_COUNT,
    input wire logic FRAME_START
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////////////////////
    // Gate: zero remaining can never exceed any threshold
    a_start_nonzero: assert property (LS_START |-> FRAME_REMAINING_COUNT != 14'h0)
        else $error("start with no frame time left");
    a_gate_split: assert property ((LS_START || LS_DEFER) == LS_REQUEST && !(LS_START && LS_DEFER))
        else $error("request not split into start or defer");
    ////////////////////////////////////////////////////////////////////////////
    // Frame countdown
    a_tick_decrement: assert property (BIT_TICK && FRAME_REMAINING_COUNT != 14'h0 |=>
        FRAME_REMAINING_COUNT == $past(FRAME_REMAINING_COUNT) - 14'h1
        || FRAME_REMAINING_COUNT == $past(FRAME_LENGTH_VALUE))
        else $error("count did not step down on tick");
    a_count_hold: assert property (!BIT_TICK && FRAME_REMAINING_COUNT != 14'h0 |=>
        $stable(FRAME_REMAINING_COUNT) || FRAME_REMAINING_COUNT == $past(FRAME_LENGTH_VALUE))
        else $error("count moved without a tick");
    a_frame_reload: assert property (FRAME_START |-> FRAME_REMAINING_COUNT == FRAME_LENGTH_VALUE)
        else $error("frame start without reload");
    ////////////////////////////////////////////////////////////////////////////
    // Register bus timing, so register rules are reachable
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read response late");
    a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
        && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
        && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while answer pending");
    c_start: cover property (LS_START);
    c_defer: cover property (LS_DEFER);
    c_frame: cover property (FRAME_START);
    c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
endmodule // lsgate_checker

bind usb_lowspeed_gate lsgate_checker u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .BIT_TICK(BIT_TICK), .FRAME_LENGTH_VALUE(FRAME_LENGTH_VALUE), .LS_REQUEST(LS_REQUEST),
    .LS_START(LS_START), .LS_DEFER(LS_DEFER),
    .FRAME_REMAINING_COUNT(FRAME_REMAINING_COUNT), .FRAME_START(FRAME_START));

/* File: verification/tick_source.sv */
// Behavioural bit-time tick source standing in for the frame timing side
`timescale 1ns/1ns
module tick_source
#(
    parameter int DIV = 8
)
(
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    int cnt = 0;
    initial tick = 1'b0;
    // Even spacing keeps every frame the same length in cycles
    always @(posedge clk)
    begin
        cnt <= (rst || cnt == DIV - 1) ? 0 : cnt + 1;
        tick <= !rst && cnt == DIV - 1;
    end
endmodule // tick_source

/* File: verification/test_usb_lowspeed_gate.sv */
// Self-checking bench for the low-speed gate and root hub descriptor
`timescale 1ns/1ns
module test_usb_lowspeed_gate;
    import lsgate_pkg::*;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
    localparam logic [13:0] LEN = 14'h0040;
    localparam logic [13:0] THR = 14'h0020;
    localparam int DIV = 8;
    logic clk, rst, awv, wv, bready, arv, rready, ls_req, tick;
    logic awready, wready, bvalid, arready, rvalid, ls_start, ls_defer, fstart;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, data;
    logic [1:0] bresp, rresp, resp;
    logic [3:0] strb;
    logic [13:0] flen, remain;
    int failures, num_checks, per;
    row_t rows[6];
    usb_lowspeed_gate DUT (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .BIT_TICK(tick), .FRAME_LENGTH_VALUE(flen), .LS_REQUEST(ls_req), .LS_START(ls_start),
        .LS_DEFER(ls_defer), .FRAME_REMAINING_COUNT(remain), .FRAME_START(fstart));
    tick_source #(.DIV(DIV)) u_tick (.clk(clk), .rst(rst), .tick(tick));
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic to_fail;
        failures++;
        $display("[ERR] wait limit exp 1 got 0");
        print_verdict();
    endtask
    // Bus tasks start right after a rising edge and end on one
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        int k;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        k = 0;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge clk);
            ta = awv && awready;
            tw = wv && wready;
            tb = bvalid && bready;
            r = bresp;
            k++;
            if (k > 50) to_fail();
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        // Ready stays up between transfers so no edge sees it lowered and raised at once
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        int k;
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        k = 0;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge clk);
            ta = arv && arready;
            tr = rvalid && rready;
            d = rdata;
            r = rresp;
            k++;
            if (k > 50) to_fail();
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end
    endtask
    task automatic wait_cnt(input logic [13:0] v);
        int k;
        for (k = 0; remain !== v; k++)
        begin
            @(negedge clk);
            if (k > 2000) to_fail();
        end
    endtask
    task automatic wait_fs(output int k);
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
            if (k > 2000) to_fail();
        end
        while (fstart !== 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        {rst, awv, wv, bready, arv, rready, ls_req} = 7'h41;
        {awaddr, araddr, wdata, flen} = {8'h00, 8'h00, 32'h0, LEN};
        strb = 4'hF;
        failures = 0;
        num_checks = 0;
        rows[0] = '{ADDR_THRESHOLD, 32'hFFFF_FFFF, 32'h0000_3FFF, RESP_OKAY};
        rows[1] = '{ADDR_DESCRIPTOR, 32'hFFFF_FFFF, 32'hFF00_1000, RESP_OKAY};
        rows[2] = '{ADDR_DESCRIPTOR, 32'h3C00_0000, 32'h3C00_0000, RESP_OKAY};
        rows[3] = '{8'h20, 32'h1234_5678, 32'h0, RESP_SLVERR};
        rows[4] = '{ADDR_STATUS, 32'hFFFF_FFFF, {18'h0, LEN}, RESP_OKAY};
        rows[5] = '{ADDR_DEFER_COUNT, 32'hFFFF_FFFF, 32'h0, RESP_OKAY};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axi_rd(ADDR_THRESHOLD, data, resp);
        `CHK("thr reset", 32'h0, data)
        axi_rd(ADDR_DESCRIPTOR, data, resp);
        `CHK("desc reset", 32'h0000_1000, data)
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            axi_wr(rows[i].a, rows[i].d, resp);
            `CHK("bresp", rows[i].r, resp)
            axi_rd(rows[i].a, data, resp);
            `CHK("rdata", rows[i].e, data)
            `CHK("rresp", rows[i].r, resp)
        end
        $display("test table done");
        // Threshold set once, leaving room for a slow packet
        axi_wr(ADDR_THRESHOLD, {18'h0, THR}, resp);
        axi_wr(ADDR_CONTROL, 32'h1, resp);
        wait_cnt(THR + 14'h2);
        @(posedge clk);
        ls_req <= 1'b1;
        wait_cnt(THR + 14'h1);
        `CHK("start above", 2'b10, {ls_start, ls_defer})
        wait_cnt(THR);
        `CHK("start at", 2'b01, {ls_start, ls_defer})
        @(posedge clk);
        ls_req <= 1'b0;
        axi_rd(ADDR_DEFER_COUNT, data, resp);
        `CHK("defers", 32'h1, data)
        $display("test gate done");
        // Power-good delay is preset before frames are timed
        axi_wr(ADDR_DESCRIPTOR, 32'hFF00_1000, resp);
        wait_fs(per);
        `CHK("reload", LEN, remain)
        wait_fs(per);
        `CHK("period", (int'(LEN) + 1) * DIV, per)
        $display("test frame done");
        // Upper lane only; the driver reads back its port power wait
        @(posedge clk);
        strb <= 4'h8;
        axi_wr(ADDR_DESCRIPTOR, 32'h0500_0000, resp);
        axi_rd(ADDR_DESCRIPTOR, data, resp);
        `CHK("pgd lane", 32'h0500_1000, data)
        $display("test strobe done");
        print_verdict();
    end
endmodule // test_usb_lowspeed_gate
